// >>> inc/clock_divider_regs.svh
/*
 * constants of the synchronous divide-by-2/4/8 block: counter reset value,
 * output bit positions and reset recovery edge counts.
 * assumes it is included by bare name from the divider design file.
 */
`ifndef CLOCK_DIVIDER_REGS_SVH
`define CLOCK_DIVIDER_REGS_SVH

`define DIV_COUNT_RESET 3'h0
`define DIV_COUNT_ONE 3'h1
`define DIV_HALF_BIT 0
`define DIV_QUARTER_BIT 1
`define DIV_EIGHTH_BIT 2
`define DIV_EDGES_CLOCK_HIGH 2'h2
`define DIV_EDGES_CLOCK_LOW 2'h3
`define DIV_EDGES_LAST 2'h1

`endif

// >>> inc/clock_divider_pkg.sv
/*
 * types of the synchronous divide-by-2/4/8 block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package clock_divider_pkg;

    typedef enum logic [1:0] {
        div_clear,
        div_recover,
        div_run
    } div_state_e;

endpackage

// >>> hw/level_edge_detect.sv
/*
 * edge finder for a level that is already synchronous to clk.
 * assumes the input needs no synchroniser; rise and fall are combinational.
 */
`timescale 1ns/100ps

module level_edge_detect (
    input wire logic clk,
    input wire logic reset,
    input wire logic level,
    output logic rise,
    output logic fall
);

    logic level_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level;
        end
    end

    assign rise = level & ~level_q;
    assign fall = ~level & level_q;

endmodule

// >>> hw/sync_clock_divider_freeze.sv
/*
 * divide-by-2, 4 and 8 of a sampled source clock, with master clear and
 * a freeze enable taken on falling source edges.
 * assumes src_clock, divider_clear and freeze_enable are synchronous to clk
 * and that clk is fast enough to see every source clock level.
 */
`timescale 1ns/100ps
`include "clock_divider_regs.svh"

// What this block does
// RULE1 - clear released with source clock high: outputs toggle on second rising edge
// RULE2 - clear released with source clock low: outputs toggle on third rising edge
// RULE3 - freeze takes effect at first falling source edge after its assertion
// RULE4 - while frozen in the run state the counter holds unless divider_clear zeroes it, outputs keep their levels
// RULE5 - freeze released at next falling edge; counting resumes with phases kept
// RULE6 - one synchronous counter gives all three outputs; clear holds it at zero

module sync_clock_divider_freeze #(
    parameter int COUNT_WIDTH = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic src_clock,
    input wire logic divider_clear,
    input wire logic freeze_enable,
    output logic half_rate_out,
    output logic quarter_rate_out,
    output logic eighth_rate_out
);

    clock_divider_pkg::div_state_e state;
    clock_divider_pkg::div_state_e next_state;
    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH-1:0] next_count;
    logic [1:0] edges_left;
    logic [1:0] next_edges_left;
    logic frozen;
    logic next_frozen;
    logic src_rise;
    logic src_fall;

    ////////////////////////////////////////////////////////////////////////

    level_edge_detect src_edges (
        .clk(clk),
        .reset(reset),
        .level(src_clock),
        .rise(src_rise),
        .fall(src_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode of the next state, counter and freeze latch

    wire in_clear = (state == clock_divider_pkg::div_clear);
    wire in_recover = (state == clock_divider_pkg::div_recover);
    wire in_run = (state == clock_divider_pkg::div_run);
    // the source level at the release cycle picks the recovery length
    wire [1:0] release_edges = src_clock ? `DIV_EDGES_CLOCK_HIGH : `DIV_EDGES_CLOCK_LOW;
    wire last_skip = in_recover & src_rise & (edges_left == `DIV_EDGES_LAST);
    // frozen only changes on falling edges, so rising edges never race it
    wire advance = (in_run & src_rise & ~frozen) | last_skip;

    always_comb begin
        next_state = state;
        next_edges_left = edges_left;
        case (state)
            clock_divider_pkg::div_clear: begin
                if (!divider_clear) begin
                    next_state = clock_divider_pkg::div_recover;
                    next_edges_left = release_edges; // [RULE1] [RULE2]
                end
            end
            clock_divider_pkg::div_recover: begin
                if (last_skip) begin
                    next_state = clock_divider_pkg::div_run; // [RULE1] [RULE2]
                end else if (src_rise) begin
                    next_edges_left = edges_left - `DIV_EDGES_LAST;
                end
            end
            clock_divider_pkg::div_run: begin
                next_state = clock_divider_pkg::div_run;
            end
            default: begin
                next_state = clock_divider_pkg::div_clear;
            end
        endcase
        if (divider_clear) begin
            next_state = clock_divider_pkg::div_clear;
        end
    end

    // one counter feeds every output, so common edges line up
    always_comb begin
        if (divider_clear) begin
            next_count = COUNT_WIDTH'(`DIV_COUNT_RESET); // [RULE6]
        end else if (advance) begin
            next_count = count + COUNT_WIDTH'(`DIV_COUNT_ONE); // [RULE5] [RULE6]
        end else begin
            next_count = count; // [RULE4]
        end
    end

    // freeze sampled only at falling source edges
    assign next_frozen = src_fall ? freeze_enable : frozen; // [RULE3] [RULE5]

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= clock_divider_pkg::div_clear;
            count <= COUNT_WIDTH'(`DIV_COUNT_RESET);
            edges_left <= `DIV_EDGES_CLOCK_LOW;
            frozen <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            edges_left <= next_edges_left;
            frozen <= next_frozen;
        end
    end

    assign half_rate_out = count[`DIV_HALF_BIT];
    assign quarter_rate_out = count[`DIV_QUARTER_BIT];
    assign eighth_rate_out = count[`DIV_EIGHTH_BIT];

    ////////////////////////////////////////////////////////////////////////
    // checks

    release_high_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
        (in_clear && !divider_clear && src_clock)
        |=> (in_recover && edges_left == 2'h2))
        else $error("release with clock high did not wait two rising edges");

    release_low_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
        (in_clear && !divider_clear && !src_clock)
        |=> (in_recover && edges_left == 2'h3))
        else $error("release with clock low did not wait three rising edges");

    recover_hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
        (in_recover && !divider_clear && !(src_rise && edges_left == 2'h1))
        |=> (count == 3'h0))
        else $error("outputs toggled before the recovery edge");

    freeze_take_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
        (src_fall && freeze_enable) |=> frozen)
        else $error("freeze not taken at the falling edge");

    frozen_hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
        (frozen && !src_fall && !divider_clear) |=> $stable(count))
        else $error("divider moved while frozen");

    resume_count_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
        (in_run && !frozen && src_rise && !divider_clear)
        |=> (count == $past(count) + 3'h1))
        else $error("divider did not step to next count after unfreeze");

    unfreeze_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
        (src_fall && !freeze_enable) |=> !frozen)
        else $error("freeze not released at the falling edge");

    clear_zero_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
        divider_clear |=> (count == 3'h0 && in_clear))
        else $error("clear did not hold the counter at zero");

    recover_step_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
        (last_skip && !divider_clear)
        |=> (in_run && count == COUNT_WIDTH'(`DIV_COUNT_ONE)))
        else $error("last recovery edge did not start the divider at one");

    recover_count_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
        (in_recover && src_rise && !last_skip && !divider_clear)
        |=> (in_recover && edges_left == $past(edges_left) - `DIV_EDGES_LAST))
        else $error("recovery did not count one rising edge");

    freeze_steady_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
        (!src_fall) |=> $stable(frozen))
        else $error("freeze state changed away from a falling edge");

    outputs_hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
        (in_run && frozen && !divider_clear)
        |=> $stable({eighth_rate_out, quarter_rate_out, half_rate_out}))
        else $error("outputs moved while frozen");

    idle_hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
        (in_run && !src_rise && !divider_clear) |=> $stable(count))
        else $error("divider moved without a rising source edge");

    // a carry into a higher output must land with the lower ones low
    quarter_align_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
        $rose(quarter_rate_out) |-> !half_rate_out)
        else $error("quarter rate edge not aligned with half rate edge");

    eighth_align_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
        $rose(eighth_rate_out) |-> (!half_rate_out && !quarter_rate_out))
        else $error("eighth rate edge not aligned with lower rate edges");

endmodule

// >>> verification/src_clock_model.sv
/*
 * source clock model: toggles every half_cycles clk cycles while run is high.
 * assumes run and half_cycles change at the falling clk edge, half_cycles >= 2.
 */
`timescale 1ns/100ps
module src_clock_model (
    input wire logic clk,
    input wire logic run,
    input wire logic [2:0] half_cycles,
    output logic src_clock
);
    logic [2:0] ticks;
    initial begin
        src_clock = 1'b0;
        ticks = 3'h0;
    end
    // a stopped source holds its level, so no stray edge reaches the divider
    always @(negedge clk) begin
        if (run) begin
            ticks <= (ticks + 3'h1 >= half_cycles) ? 3'h0 : ticks + 3'h1;
            if (ticks + 3'h1 >= half_cycles) src_clock <= ~src_clock;
        end
    end
endmodule

// >>> verification/sync_clock_divider_freeze_tb_top.sv
/*
 * testbench: clear recovery from both source levels, counting, freeze.
 * assumes src_clock_model drives the source clock.
 */
`timescale 1ns/100ps
module sync_clock_divider_freeze_tb_top;
    logic clk, reset, divider_clear, freeze_enable, run, src_clock;
    logic half_rate_out, quarter_rate_out, eighth_rate_out;
    logic [2:0] half_cycles, count;
    logic [2:0] expect_q[$];
    int err_total, comparisons;
    sync_clock_divider_freeze DUT (.clk(clk), .reset(reset), .src_clock(src_clock),
        .divider_clear(divider_clear), .freeze_enable(freeze_enable),
        .half_rate_out(half_rate_out), .quarter_rate_out(quarter_rate_out),
        .eighth_rate_out(eighth_rate_out));
    src_clock_model source (.clk(clk), .run(run), .half_cycles(half_cycles),
        .src_clock(src_clock));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [2:0] seen, input logic [2:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] outputs expected %h seen %h", want, seen);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // sampled three clk cycles after each source rise so a registered step has landed
    always @(posedge src_clock) begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        if (expect_q.size() > 0) begin
            check({eighth_rate_out, quarter_rate_out, half_rate_out}, expect_q.pop_front());
        end
    end
    task automatic rises(input int n);
        repeat (n) @(posedge src_clock);
        repeat (4) @(negedge clk);
    endtask
    task automatic recover(input logic level, input int lag);
        @(negedge clk) divider_clear <= 1'b1;
        do begin
            @(negedge clk) run <= 1'b1;
            repeat ($urandom_range(7, 1)) @(negedge clk);
            run <= 1'b0;
            @(negedge clk);
        end while (src_clock !== level);
        repeat (2) @(negedge clk);
        divider_clear <= 1'b0;
        for (int i = 1; i <= 12; i++) begin
            expect_q.push_back(i < lag ? 3'h0 : 3'(i - lag + 1));
        end
        repeat (2) @(negedge clk);
        run <= 1'b1;
        rises(12);
    endtask
    task automatic freeze_test(input logic [2:0] start);
        int hold;
        hold = $urandom_range(5, 1);
        count = start + 3'h1;
        expect_q.push_back(count);
        @(posedge src_clock);
        @(negedge clk) freeze_enable <= 1'b1;
        repeat (hold) expect_q.push_back(count);
        repeat (hold) @(posedge src_clock);
        @(negedge clk) freeze_enable <= 1'b0;
        for (int i = 1; i <= 3; i++) expect_q.push_back(count + 3'(i));
        rises(3);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(50245));
        reset = 1'b1;
        divider_clear = 1'b1;
        freeze_enable = 1'b0;
        run = 1'b0;
        half_cycles = 3'h3;
        err_total = 0;
        comparisons = 0;
        repeat (2) @(negedge clk);
        reset <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            half_cycles <= 3'($urandom_range(5, 3));
            recover(k[0], k[0] ? 2 : 3);
            freeze_test(3'(13 - (k[0] ? 2 : 3)));
        end
        complete_run();
    end
    initial begin
        #300us;
        err_total++;
        complete_run();
    end
endmodule
